// file: design/setu_pkg.sv
package setu_pkg;
  localparam int          SAMPLE_W     = 12;
  localparam int          NUM_CH       = 4;
  localparam int          AXI_AW       = 6;
  // Register byte addresses
  localparam logic [5:0]  CTRL_OFS     = 6'h00;
  localparam logic [5:0]  THRESH_OFS   = 6'h04;
  localparam logic [5:0]  COMMIT_OFS   = 6'h08;
  localparam logic [5:0]  STATUS_OFS   = 6'h0C;
  localparam logic [5:0]  IRQ_STAT_OFS = 6'h10;
  localparam logic [5:0]  IRQ_EN_OFS   = 6'h14;
  localparam logic [5:0]  IRQ_CLR_OFS  = 6'h18;
  localparam logic [5:0]  TRIG_IDX_OFS = 6'h1C;
  // CTRL and THRESH field positions and reset values
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_CH_LSB   = 2;
  localparam int          CTRL_DIR_LSB  = 4;
  localparam int          CTRL_HYS_BIT  = 6;
  localparam int          CTRL_ARM_BIT  = 7;
  localparam int          THR_HYS_LSB   = 16;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] THRESH_RESET  = 32'h0000_0000;
  // Interrupt bits
  localparam int          IRQ_TRIG_BIT  = 0;
  localparam int          IRQ_FORCE_BIT = 1;
  localparam int          IRQ_W         = 2;
  // Auto-mode timeout and AXI response codes
  localparam int          CLK_MHZ       = 100;
  localparam int          AUTO_TMO_US   = 100;
  localparam int          AUTO_TMO_CYC  = AUTO_TMO_US * CLK_MHZ;
  localparam logic [1:0]  AXI_OKAY      = 2'h0;
  localparam logic [1:0]  AXI_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    SETU_MODE_NONE   = 2'h0,
    SETU_MODE_AUTO   = 2'h1,
    SETU_MODE_REPEAT = 2'h2,
    SETU_MODE_SINGLE = 2'h3
  } setu_mode_e;

  typedef enum logic [1:0] {
    SETU_DIR_RISE = 2'h0,
    SETU_DIR_FALL = 2'h1,
    SETU_DIR_BOTH = 2'h2,
    SETU_DIR_RSVD = 2'h3
  } setu_dir_e;

  typedef struct packed {
    setu_mode_e            mode;
    logic [1:0]            chan;
    setu_dir_e             dir;
    logic                  hys_en;
    logic                  arm;
    logic [SAMPLE_W-1:0]   thresh;
    logic [SAMPLE_W-1:0]   hys_thresh;
  } setu_cfg_s;
endpackage

// file: design/setu_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface setu_cfg_if;
  import setu_pkg::*;
  setu_cfg_s           cfg;
  logic                hit;
  logic                hit_rise;
  logic [SAMPLE_W-1:0] sel_sample;
  logic                sel_valid;
  modport ctrl (output cfg, output sel_sample, output sel_valid, input hit, input hit_rise);
  modport det  (input cfg, input sel_sample, input sel_valid, output hit, output hit_rise);
endinterface
`default_nettype wire

// file: design/setu_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module setu_edge_det (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Detector link
  setu_cfg_if.det   lnk
);
  import setu_pkg::*;

  logic                prev_reg, prev_next;
  logic                seen_reg, seen_next;
  logic                armr_reg, armr_next;
  logic                armf_reg, armf_next;
  logic                hit_reg,  hit_next;
  logic                hr_reg,   hr_next;
  logic                above, above_hi, above_lo, rise, fall;

  // ----------------------------------------------------------------
  // Threshold crossing and hysteresis arming
  // ----------------------------------------------------------------
  always_comb begin
    above     = lnk.sel_sample >= lnk.cfg.thresh;
    above_hi  = lnk.sel_sample >= lnk.cfg.hys_thresh;
    above_lo  = lnk.sel_sample < lnk.cfg.hys_thresh;
    rise      = seen_reg && !prev_reg && above;
    fall      = seen_reg && prev_reg && !above;
    prev_next = prev_reg;
    seen_next = seen_reg;
    armr_next = armr_reg;
    armf_next = armf_reg;
    hit_next  = 1'b0;
    hr_next   = 1'b0;
    if (lnk.sel_valid) begin
      prev_next = above;
      seen_next = 1'b1;
      if (lnk.cfg.hys_en) begin
        // Below both levels arms rise, above both arms fall
        if (above_lo && !above) armr_next = 1'b1;
        if (above_hi && above)  armf_next = 1'b1;
      end
      unique case (lnk.cfg.dir)
        SETU_DIR_RISE: hit_next = rise && (!lnk.cfg.hys_en || armr_reg);
        SETU_DIR_FALL: hit_next = fall && (!lnk.cfg.hys_en || armf_reg);
        SETU_DIR_BOTH: hit_next = (rise && (!lnk.cfg.hys_en || armr_reg))
                                || (fall && (!lnk.cfg.hys_en || armf_reg));
        default:       hit_next = 1'b0;
      endcase
      hr_next = rise;
      if (hit_next && rise) armr_next = 1'b0;
      if (hit_next && fall) armf_next = 1'b0;
    end
    // Arming is held cleared while hysteresis is off
    if (!lnk.cfg.hys_en) begin
      armr_next = 1'b0;
      armf_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 1'b0;
      seen_reg <= 1'b0;
      armr_reg <= 1'b0;
      armf_reg <= 1'b0;
      hit_reg  <= 1'b0;
      hr_reg   <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      seen_reg <= seen_next;
      armr_reg <= armr_next;
      armf_reg <= armf_next;
      hit_reg  <= hit_next;
      hr_reg   <= hr_next;
    end
  end

  assign lnk.hit      = hit_reg;
  assign lnk.hit_rise = hr_reg;

  hys_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lnk.sel_valid && lnk.cfg.hys_en && lnk.cfg.dir == SETU_DIR_RISE && !armr_reg) |=> !hit_reg)
    else $error("hysteresis rise hit without arming");
  rise_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lnk.sel_valid && !lnk.cfg.hys_en && lnk.cfg.dir == SETU_DIR_RISE && rise) |=> hit_reg)
    else $error("rising crossing missed");
  fall_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lnk.sel_valid && lnk.cfg.dir == SETU_DIR_FALL && !fall) |=> !hit_reg)
    else $error("fall hit without falling crossing");
endmodule
`default_nettype wire

// file: design/setu_trigger_top.sv
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Four trigger modes exist: none, auto, repeat and single.
// - None mode captures every sample without waiting for a trigger.
// - Auto mode waits for a trigger and forces capture after a timeout.
// - Repeat mode captures only after each trigger and delivers nothing otherwise.
// - Single mode stops acquiring after the first trigger.
// - Only the selected trigger channel is evaluated.
// - Samples are compared with a programmable threshold; a crossing is an event.
// - Rise direction fires on an upward crossing.
// - Fall direction fires on a downward crossing.
// - Both direction fires on crossings of either polarity.
// - Hysteresis adds a second threshold against noise.
// - With hysteresis the second level arms and the main level fires.
module setu_trigger_top #(
  parameter int AUTO_TMO = setu_pkg::AUTO_TMO_CYC
) (
  // Clock and reset
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // AXI4-Lite slave
  input  wire logic [setu_pkg::AXI_AW-1:0]      s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output var  logic                             s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output var  logic                             s_axi_wready,
  output var  logic [1:0]                       s_axi_bresp,
  output var  logic                             s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [setu_pkg::AXI_AW-1:0]      s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output var  logic                             s_axi_arready,
  output var  logic [31:0]                      s_axi_rdata,
  output var  logic [1:0]                       s_axi_rresp,
  output var  logic                             s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // Sample stream from front end
  input  wire logic [setu_pkg::NUM_CH*setu_pkg::SAMPLE_W-1:0] smp_data,
  input  wire logic                             smp_valid,
  // Capture, trigger and interrupt outputs
  output var  logic                             cap_en,
  output var  logic                             trig_pulse,
  output var  logic                             irq
);
  import setu_pkg::*;

  if (AUTO_TMO < 1) begin : g_bad_tmo
    $error("AUTO_TMO must be at least 1");
  end

  setu_cfg_if lnk ();

  typedef enum logic [1:0] {
    SETU_ST_IDLE = 2'h0,
    SETU_ST_WAIT = 2'h1,
    SETU_ST_HOLD = 2'h2
  } setu_state_e;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0]         ctrl_reg,   ctrl_next;
  logic [31:0]         thr_reg,    thr_next;
  setu_cfg_s           act_reg,    act_next;
  logic [IRQ_W-1:0]    ist_reg,    ist_next;
  logic [IRQ_W-1:0]    ien_reg,    ien_next;
  logic                awr_reg,    awr_next;
  logic                wr_reg,     wr_next;
  logic                bv_reg,     bv_next;
  logic [1:0]          br_reg,     br_next;
  logic                arr_reg,    arr_next;
  logic                rv_reg,     rv_next;
  logic [31:0]         rd_reg,     rd_next;
  logic [1:0]          rr_reg,     rr_next;
  logic [AXI_AW-1:0]   awa_reg,    awa_next;
  logic                awh_reg,    awh_next;
  logic [31:0]         wd_reg,     wd_next;
  logic                wh_reg,     wh_next;
  logic [IRQ_W-1:0]    clr_w;
  logic                commit_w;

  // Acquisition state
  setu_state_e         st_reg,     st_next;
  logic                cap_reg,    cap_next;
  logic                tp_reg,     tp_next;
  logic                irq_reg,    irq_next;
  logic [31:0]         idx_reg,    idx_next;
  logic [31:0]         tidx_reg,   tidx_next;
  logic [31:0]         tmo_reg,    tmo_next;
  logic [IRQ_W-1:0]    ev_w;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  always_comb begin
    awr_next = 1'b0;
    wr_next  = 1'b0;
    awa_next = awa_reg;
    awh_next = awh_reg;
    wd_next  = wd_reg;
    wh_next  = wh_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    ctrl_next = ctrl_reg;
    thr_next  = thr_reg;
    ien_next  = ien_reg;
    clr_w     = '0;
    commit_w  = 1'b0;
    if (s_axi_awvalid && !awh_reg && !awr_reg) begin
      awr_next = 1'b1;
    end
    if (s_axi_awvalid && awr_reg) begin
      awa_next = s_axi_awaddr;
      awh_next = 1'b1;
    end
    if (s_axi_wvalid && !wh_reg && !wr_reg) begin
      wr_next = 1'b1;
    end
    if (s_axi_wvalid && wr_reg) begin
      wd_next = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
      wh_next = 1'b1;
      if (awh_reg || (s_axi_awvalid && awr_reg)) begin
      end
    end
    if (awh_reg && wh_reg && !bv_reg) begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = AXI_OKAY;
      unique case (awa_reg)
        CTRL_OFS:    ctrl_next = wd_reg;
        THRESH_OFS:  thr_next  = wd_reg;
        COMMIT_OFS:  commit_w  = 1'b1;
        IRQ_EN_OFS:  ien_next  = wd_reg[IRQ_W-1:0];
        IRQ_CLR_OFS: clr_w     = wd_reg[IRQ_W-1:0];
        STATUS_OFS, IRQ_STAT_OFS, TRIG_IDX_OFS: br_next = AXI_OKAY;
        default:     br_next   = AXI_SLVERR;
      endcase
    end
    if (bv_reg && s_axi_bready) bv_next = 1'b0;
  end

  always_comb begin
    arr_next = 1'b0;
    rv_next  = rv_reg;
    rd_next  = rd_reg;
    rr_next  = rr_reg;
    if (s_axi_arvalid && !rv_reg && !arr_reg) arr_next = 1'b1;
    if (s_axi_arvalid && arr_reg) begin
      rv_next = 1'b1;
      rr_next = AXI_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFS:     rd_next = ctrl_reg;
        THRESH_OFS:   rd_next = thr_reg;
        STATUS_OFS:   rd_next = {28'h0000000, cap_reg, act_reg.arm, st_reg};
        IRQ_STAT_OFS: rd_next = {{(32-IRQ_W){1'b0}}, ist_reg};
        IRQ_EN_OFS:   rd_next = {{(32-IRQ_W){1'b0}}, ien_reg};
        TRIG_IDX_OFS: rd_next = tidx_reg;
        COMMIT_OFS, IRQ_CLR_OFS: rd_next = 32'h0000_0000;
        default: begin
          rd_next = 32'h0000_0000;
          rr_next = AXI_SLVERR;
        end
      endcase
    end
    if (rv_reg && s_axi_rready) rv_next = 1'b0;
  end

  // Shadow to active copy in one cycle
  always_comb begin
    act_next = act_reg;
    if (commit_w) begin
      act_next.mode       = setu_mode_e'(ctrl_reg[CTRL_MODE_LSB +: 2]);
      act_next.chan       = ctrl_reg[CTRL_CH_LSB +: 2];
      act_next.dir        = setu_dir_e'(ctrl_reg[CTRL_DIR_LSB +: 2]);
      act_next.hys_en     = ctrl_reg[CTRL_HYS_BIT];
      act_next.arm        = ctrl_reg[CTRL_ARM_BIT];
      act_next.thresh     = thr_reg[SAMPLE_W-1:0];
      act_next.hys_thresh = thr_reg[THR_HYS_LSB +: SAMPLE_W];
    end
  end

  // ----------------------------------------------------------------
  // Channel select and acquisition control
  // ----------------------------------------------------------------
  assign lnk.cfg        = act_reg;
  assign lnk.sel_sample = smp_data[act_reg.chan*SAMPLE_W +: SAMPLE_W];
  assign lnk.sel_valid  = smp_valid;

  always_comb begin
    st_next   = st_reg;
    cap_next  = cap_reg;
    tp_next   = 1'b0;
    idx_next  = idx_reg;
    tidx_next = tidx_reg;
    tmo_next  = tmo_reg;
    ev_w      = '0;
    if (smp_valid) idx_next = idx_reg + 32'h0000_0001;
    if (!act_reg.arm || act_reg.mode == SETU_MODE_NONE) begin
      st_next  = SETU_ST_IDLE;
      cap_next = 1'b1;
      tmo_next = '0;
    end else begin
      unique case (st_reg)
        SETU_ST_IDLE: begin
          st_next  = SETU_ST_WAIT;
          cap_next = 1'b0;
          tmo_next = '0;
        end
        SETU_ST_WAIT: begin
          if (lnk.hit) begin
            tp_next   = 1'b1;
            tidx_next = idx_reg - 32'h0000_0001;
            ev_w[IRQ_TRIG_BIT] = 1'b1;
            cap_next  = act_reg.mode != SETU_MODE_SINGLE;
            tmo_next  = '0;
            if (act_reg.mode == SETU_MODE_SINGLE) st_next = SETU_ST_HOLD;
          end else if (act_reg.mode == SETU_MODE_AUTO && tmo_reg >= 32'(AUTO_TMO - 1)) begin
            cap_next = 1'b1;
            ev_w[IRQ_FORCE_BIT] = 1'b1;
            tmo_next = '0;
          end else begin
            tmo_next = tmo_reg + 32'h0000_0001;
            if (act_reg.mode != SETU_MODE_AUTO) cap_next = 1'b0;
          end
        end
        SETU_ST_HOLD: cap_next = 1'b0;
        default:      st_next  = SETU_ST_IDLE;
      endcase
    end
    ist_next = (ist_reg & ~clr_w) | ev_w;
    irq_next = |(ist_next & ien_reg);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      thr_reg  <= THRESH_RESET;
      act_reg  <= '0;
      ist_reg  <= '0;
      ien_reg  <= '0;
      awr_reg  <= 1'b0;
      wr_reg   <= 1'b0;
      bv_reg   <= 1'b0;
      br_reg   <= AXI_OKAY;
      arr_reg  <= 1'b0;
      rv_reg   <= 1'b0;
      rd_reg   <= 32'h0000_0000;
      rr_reg   <= AXI_OKAY;
      awa_reg  <= '0;
      awh_reg  <= 1'b0;
      wd_reg   <= 32'h0000_0000;
      wh_reg   <= 1'b0;
      st_reg   <= SETU_ST_IDLE;
      cap_reg  <= 1'b0;
      tp_reg   <= 1'b0;
      irq_reg  <= 1'b0;
      idx_reg  <= 32'h0000_0000;
      tidx_reg <= 32'h0000_0000;
      tmo_reg  <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      thr_reg  <= thr_next;
      act_reg  <= act_next;
      ist_reg  <= ist_next;
      ien_reg  <= ien_next;
      awr_reg  <= awr_next;
      wr_reg   <= wr_next;
      bv_reg   <= bv_next;
      br_reg   <= br_next;
      arr_reg  <= arr_next;
      rv_reg   <= rv_next;
      rd_reg   <= rd_next;
      rr_reg   <= rr_next;
      awa_reg  <= awa_next;
      awh_reg  <= awh_next;
      wd_reg   <= wd_next;
      wh_reg   <= wh_next;
      st_reg   <= st_next;
      cap_reg  <= cap_next;
      tp_reg   <= tp_next;
      irq_reg  <= irq_next;
      idx_reg  <= idx_next;
      tidx_reg <= tidx_next;
      tmo_reg  <= tmo_next;
    end
  end

  setu_edge_det u_det (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lnk     (lnk)
  );

  assign s_axi_awready = awr_reg;
  assign s_axi_wready  = wr_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  assign cap_en        = cap_reg;
  assign trig_pulse    = tp_reg;
  assign irq           = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_trig_single;
    lnk.hit && st_reg == SETU_ST_WAIT && act_reg.arm && act_reg.mode == SETU_MODE_SINGLE;
  endsequence

  none_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (act_reg.mode == SETU_MODE_NONE && act_reg.arm) |=> cap_reg)
    else $error("none mode not capturing");
  single_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_trig_single |=> (!cap_reg && st_reg == SETU_ST_HOLD) ##1 (!cap_reg || !act_reg.arm || commit_w))
    else $error("single mode kept acquiring");
  auto_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg == SETU_ST_WAIT && act_reg.arm && act_reg.mode == SETU_MODE_AUTO && !lnk.hit
     && tmo_reg == 32'(AUTO_TMO - 1)) |=> (cap_reg && ist_reg[IRQ_FORCE_BIT]))
    else $error("auto timeout did not force capture");
  repeat_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg == SETU_ST_WAIT && act_reg.arm && act_reg.mode == SETU_MODE_REPEAT && !lnk.hit) |=> !cap_reg)
    else $error("repeat mode captured without trigger");
  trig_index_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lnk.hit && st_reg == SETU_ST_WAIT && act_reg.arm && act_reg.mode != SETU_MODE_NONE)
    |=> (trig_pulse && tidx_reg == $past(idx_reg) - 32'h0000_0001))
    else $error("trigger index wrong");
  untrig_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !act_reg.arm |=> cap_reg)
    else $error("capture gated while trigger disabled");
  atomic_cfg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !commit_w |=> $stable(act_reg))
    else $error("active config changed without commit");
  rise_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (lnk.hit && $past(act_reg.dir) == SETU_DIR_RISE) |-> lnk.hit_rise)
    else $error("rise hit without rise flag");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_w[IRQ_TRIG_BIT] |=> ist_reg[IRQ_TRIG_BIT])
    else $error("trigger event lost");
endmodule
`default_nettype wire

// file: tb/setu_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
module setu_fe_model (
  // Clock
  input  wire logic                                       aclk,
  // Sample stream
  output var  logic [setu_pkg::NUM_CH*setu_pkg::SAMPLE_W-1:0] smp_data,
  output var  logic                                       smp_valid
);
  import setu_pkg::*;
  logic [NUM_CH*SAMPLE_W-1:0] q[$];
  initial begin
    smp_data  = '0;
    smp_valid = 1'b0;
  end
  // Idle data toggles so a stale set never looks valid
  always @(posedge aclk) begin
    if (q.size() > 0) begin
      smp_data  <= q.pop_front();
      smp_valid <= 1'b1;
    end else begin
      smp_data  <= ~smp_data;
      smp_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/setu_trigger_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module setu_trigger_top_tb;
  import setu_pkg::*;
  localparam int TMO = 20;
  logic                       aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                       arvalid, arready, rvalid, rready, smp_valid, cap_en, trig_pulse, irq;
  logic [5:0]                 awaddr, araddr;
  logic [31:0]                wdata, rdata, rdv;
  logic [1:0]                 bresp, rresp;
  logic [NUM_CH*SAMPLE_W-1:0] smp_data;
  logic [11:0]                th, th2;
  int                         miscompares, checked, seed, sidx, prev, fires, eidx, got, ch;
  bit                         armed, sdone, hys, en, ien;
  setu_mode_e                 mode;
  setu_dir_e                  dir;

  setu_trigger_top #(.AUTO_TMO(TMO)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .smp_data(smp_data), .smp_valid(smp_valid), .cap_en(cap_en),
    .trig_pulse(trig_pulse), .irq(irq));
  setu_fe_model fe (.aclk(aclk), .smp_data(smp_data), .smp_valid(smp_valid));

  always #5 aclk = ~aclk;
  always @(posedge aclk) if (trig_pulse === 1'b1) got = got + 1;

  // ----
  // Helpers
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write response");
  endtask

  task automatic rd(input logic [5:0] a, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rdv = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er}, "read response");
  endtask

  task automatic drain();
    while (fe.q.size() != 0) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask

  // Sends one sample set and steps the reference trigger model
  task automatic smp(input int v, input bit all);
    logic [NUM_CH*SAMPLE_W-1:0] d;
    bit                         up, dn, hit;
    for (int i = 0; i < NUM_CH; i++) d[i*SAMPLE_W +: SAMPLE_W] = all ? v[11:0] : 12'($random(seed));
    if (!all) d[ch*SAMPLE_W +: SAMPLE_W] = v[11:0];
    fe.q.push_back(d);
    up = prev < th && v >= th;
    dn = prev >= th && v < th;
    hit = (dir == SETU_DIR_RISE) ? up : (dir == SETU_DIR_FALL) ? dn : (up || dn);
    if (hys && !armed) hit = 0;
    if (hit) armed = 0;
    else if (hys && ((dir == SETU_DIR_FALL) ? v >= th2 : v < th2)) armed = 1;
    if (en && hit && !sdone && mode != SETU_MODE_NONE) begin
      fires++;
      eidx = sidx;
      sdone = (mode == SETU_MODE_SINGLE);
    end
    prev = v;
    sidx++;
  endtask

  task automatic run(input setu_mode_e m, input int c, input setu_dir_e dr, input bit h);
    int v0;
    v0 = (dr == SETU_DIR_FALL) ? 0 : 4095;
    en = 0;
    wr(CTRL_OFS, 32'h0, AXI_OKAY);
    wr(COMMIT_OFS, 32'h0, AXI_OKAY);
    th = 12'h800;
    th2 = (dr == SETU_DIR_FALL) ? 12'hA00 : 12'h600;
    wr(THRESH_OFS, {4'h0, th2, 4'h0, th}, AXI_OKAY);
    wr(CTRL_OFS, {24'h0, 1'b1, h, dr, c[1:0], m}, AXI_OKAY);
    got = 0;
    if (!h) smp(4095 - v0, 1);
    smp(v0, 1);
    drain();
    chk(got, 0, "staged settings acted early");
    wr(COMMIT_OFS, 32'h0, AXI_OKAY);
    mode = m;
    dir = dr;
    hys = h;
    ch = c;
    armed = 0;
    sdone = 0;
    fires = 0;
    got = 0;
    en = 1;
    repeat (30) smp({$random(seed)} % 4096, 0);
    smp(v0, 0);
    smp(v0, 0);
    drain();
    chk(got, fires, "fire count");
    rd(IRQ_STAT_OFS, AXI_OKAY);
    chk({31'h0, rdv[0]}, fires > 0, "trigger status");
    chk({31'h0, irq}, ien && fires > 0, "irq level");
    if (fires > 0) begin
      rd(TRIG_IDX_OFS, AXI_OKAY);
      chk(rdv, eidx, "trigger index");
    end
    if (m == SETU_MODE_REPEAT || fires > 0) chk({31'h0, cap_en}, 0, "capture held");
    wr(IRQ_CLR_OFS, 32'h3, AXI_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 0, "irq clear");
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    aclk = 0;
    aresetn = 0;
    awvalid = 0;
    wvalid = 0;
    bready = 0;
    arvalid = 0;
    rready = 0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    seed = 9;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({31'h0, cap_en}, 1, "untriggered capture");
    rd(CTRL_OFS, AXI_OKAY);
    chk(rdv, CTRL_RESET, "ctrl reset");
    rd(THRESH_OFS, AXI_OKAY);
    chk(rdv, THRESH_RESET, "thresh reset");
    rd(IRQ_EN_OFS, AXI_OKAY);
    chk(rdv, 32'h0, "irq enable reset");
    rd(6'h20, AXI_SLVERR);
    wr(STATUS_OFS, 32'hFFFF_FFFF, AXI_OKAY);
    run(SETU_MODE_REPEAT, 1, SETU_DIR_RISE, 0);
    wr(IRQ_EN_OFS, 32'h1, AXI_OKAY);
    ien = 1;
    run(SETU_MODE_REPEAT, 2, SETU_DIR_FALL, 0);
    run(SETU_MODE_REPEAT, 3, SETU_DIR_BOTH, 0);
    run(SETU_MODE_REPEAT, 0, SETU_DIR_RISE, 1);
    run(SETU_MODE_REPEAT, 2, SETU_DIR_FALL, 1);
    run(SETU_MODE_SINGLE, 1, SETU_DIR_RISE, 0);
    run(SETU_MODE_SINGLE, 3, SETU_DIR_BOTH, 0);
    en = 0;
    wr(CTRL_OFS, 32'h0000_0000, AXI_OKAY);
    wr(COMMIT_OFS, 32'h0, AXI_OKAY);
    wr(CTRL_OFS, 32'h0000_0081, AXI_OKAY);
    wr(COMMIT_OFS, 32'h0, AXI_OKAY);
    repeat (3 * TMO) smp(4095, 1);
    drain();
    rd(IRQ_STAT_OFS, AXI_OKAY);
    chk({31'h0, rdv[1]}, 1, "auto force");
    wr(CTRL_OFS, 32'h0000_0080, AXI_OKAY);
    wr(COMMIT_OFS, 32'h0, AXI_OKAY);
    repeat (3) @(posedge aclk);
    chk({31'h0, cap_en}, 1, "free capture");
    report_and_stop();
  end

  initial begin
    #100000;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
